// >>> spics_pkg.sv
// shared constants and types of the spi config/status block
package spics_pkg;
  localparam logic [7:0] SPICS_OFF_CFG = 8'h00;
  localparam logic [7:0] SPICS_OFF_TXD = 8'h04;
  localparam logic [7:0] SPICS_OFF_RXD = 8'h08;
  localparam logic [7:0] SPICS_OFF_ISTAT = 8'h0C;
  localparam logic [7:0] SPICS_OFF_IMASK = 8'h10;
  localparam logic [7:0] SPICS_OFF_DIV = 8'h14;
  localparam int SPICS_BIT_BUSY = 7;
  localparam int SPICS_BIT_MST = 6;
  localparam int SPICS_BIT_CPHA = 5;
  localparam int SPICS_BIT_CPOL = 4;
  localparam int SPICS_BIT_SEL = 3;
  localparam int SPICS_BIT_RAW = 2;
  localparam int SPICS_BIT_SHIFT_EMPTY_FLAG = 1;
  localparam int SPICS_BIT_RXE = 0;
  localparam logic [7:0] SPICS_CFG_WMASK = 8'h70;
  localparam logic [7:0] SPICS_CFG_RST = 8'h00;
  localparam logic [7:0] SPICS_DIV_RST = 8'h03;
  localparam int SPICS_IRQ_W = 2;
  localparam int SPICS_IRQ_DONE = 0;
  localparam int SPICS_IRQ_SEL = 1;
  localparam logic [1:0] SPICS_IMASK_RST = 2'h0;
  localparam int SPICS_CLK_NS = 20;
  localparam int SPICS_DEGLITCH_NS = 80;
  localparam int SPICS_DEGLITCH_CYC = (SPICS_DEGLITCH_NS + SPICS_CLK_NS - 1) / SPICS_CLK_NS;
  typedef enum logic [0:0] {
    SPICS_IDLE = 1'b0,
    SPICS_RUN = 1'b1
  } spics_mst_t;
endpackage

// >>> spics_top.sv
// spi controller core around the config/status register, ahb-lite slave
`timescale 1ns/10ps
module spics_top
  import spics_pkg::*;
#(
  parameter int DEGLITCH_CYC = SPICS_DEGLITCH_CYC
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic slave_select_pin
);
  logic [7:0] cfg_q;
  logic [7:0] div_q;
  logic [7:0] txbuf_q;
  logic tx_full_q;
  logic [7:0] rxbuf_q;
  logic rx_full_q;
  logic [7:0] shift_q;
  logic out_q;
  logic busy_q;
  logic shift_empty_q;
  logic ld_q;
  logic [3:0] cnt_q;
  logic [8:0] bcnt_q;
  spics_mst_t mst_q;
  logic [SPICS_IRQ_W-1:0] istat_q;
  logic [SPICS_IRQ_W-1:0] imask_q;
  logic irq_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic sck_out_q;
  logic sck_oe_q;
  logic mosi_oe_q;
  logic miso_oe_q;
  logic [2:0] sck_sy_q;
  logic [1:0] mosi_sy_q;
  logic [1:0] miso_sy_q;
  logic [1:0] nss_sy_q;
  logic filt_q;
  logic [7:0] glitch_q;

  logic master_mode;
  logic cpha;
  logic cpol;
  logic selected_flag_filtered;
  logic select_pin_raw;
  logic shift_empty_flag;
  logic receive_empty_flag;
  logic transfer_busy_flag;
  logic addr_take;
  logic rd_take;
  logic [7:0] rd_off;
  logic tx_write;
  logic rx_read;
  logic [8:0] half;
  logic [8:0] bit_last;
  logic m_start;
  logic m_sample;
  logic m_end;
  logic s_active;
  logic s_edge;
  logic s_sample;
  logic s_shift;
  logic sample_now;
  logic sample_bit;
  logic byte_done;
  logic sel_rise;
  logic s_load;
  logic [31:0] rd_mux;

  assign master_mode = cfg_q[SPICS_BIT_MST];
  assign cpha = cfg_q[SPICS_BIT_CPHA];
  assign cpol = cfg_q[SPICS_BIT_CPOL];
  assign selected_flag_filtered = ~filt_q;
  assign select_pin_raw = nss_sy_q[1];
  assign shift_empty_flag = master_mode | shift_empty_q;
  assign receive_empty_flag = master_mode | ~rx_full_q;
  assign transfer_busy_flag = busy_q;

  // two-flop synchronisers for every pin, three flops on sck for edge detection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_sy_q <= 3'h0;
      mosi_sy_q <= 2'h0;
      miso_sy_q <= 2'h0;
      nss_sy_q <= 2'h3;
    end
    else
    begin
      sck_sy_q <= {sck_sy_q[1:0], sck_in};
      mosi_sy_q <= {mosi_sy_q[0], mosi_in};
      miso_sy_q <= {miso_sy_q[0], miso_in};
      nss_sy_q <= {nss_sy_q[0], slave_select_pin};
    end
  end

  // select pin must hold a new level for DEGLITCH_CYC cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filt_q <= 1'b1;
      glitch_q <= 8'h00;
    end
    else if (nss_sy_q[1] == filt_q)
      glitch_q <= 8'h00;
    else if (glitch_q == 8'(DEGLITCH_CYC - 1))
    begin
      filt_q <= nss_sy_q[1];
      glitch_q <= 8'h00;
    end
    else
      glitch_q <= glitch_q + 8'h01;
  end

  assign sel_rise = (nss_sy_q[1] != filt_q) && (glitch_q == 8'(DEGLITCH_CYC - 1)) && filt_q;

  // ahb-lite decode, zero wait state
  assign addr_take = hsel && htrans[1] && hready;
  assign rd_take = addr_take && !hwrite;
  assign rd_off = haddr[7:0];
  assign tx_write = wr_pend_q && (wr_addr_q == SPICS_OFF_TXD);
  assign rx_read = rd_take && (rd_off == SPICS_OFF_RXD);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (rd_off)
      SPICS_OFF_CFG: rd_mux = {24'h000000, transfer_busy_flag, cfg_q[6:4],
                               selected_flag_filtered, select_pin_raw,
                               shift_empty_flag, receive_empty_flag};
      SPICS_OFF_TXD: rd_mux = {24'h000000, txbuf_q};
      SPICS_OFF_RXD: rd_mux = {24'h000000, rxbuf_q};
      SPICS_OFF_ISTAT: rd_mux = {30'h0000_0000, istat_q};
      SPICS_OFF_IMASK: rd_mux = {30'h0000_0000, imask_q};
      SPICS_OFF_DIV: rd_mux = {24'h000000, div_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      wr_pend_q <= addr_take && hwrite;
      if (addr_take)
        wr_addr_q <= haddr[7:0];
      if (rd_take)
        hrdata_q <= rd_mux;
    end
  end

  // writable registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q <= SPICS_CFG_RST;
      div_q <= SPICS_DIV_RST;
      imask_q <= SPICS_IMASK_RST;
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == SPICS_OFF_CFG)
        cfg_q <= hwdata[7:0] & SPICS_CFG_WMASK;
      if (wr_addr_q == SPICS_OFF_DIV)
        div_q <= hwdata[7:0];
      if (wr_addr_q == SPICS_OFF_IMASK)
        imask_q <= hwdata[SPICS_IRQ_W-1:0];
    end
  end

  // master bit timing: half period is div+1 cycles
  assign half = {1'b0, div_q} + 9'h001;
  assign bit_last = {half[7:0], 1'b0} - 9'h001;
  assign m_start = master_mode && (mst_q == SPICS_IDLE) && tx_full_q;
  assign m_sample = (mst_q == SPICS_RUN) && (bcnt_q == bit_last - 9'h001);
  assign m_end = (mst_q == SPICS_RUN) && (bcnt_q == bit_last);

  // slave clock edges on the synchronised clock
  assign s_active = !master_mode && selected_flag_filtered;
  assign s_edge = s_active && (sck_sy_q[2] != sck_sy_q[1]);
  assign s_sample = s_edge && ((sck_sy_q[1] != cpol) ^ cpha);
  assign s_shift = s_edge && !s_sample;
  // a slave preloads its shift register when a byte waits, the shift register is empty and no byte is open, so bit 7 is out early
  assign s_load = !master_mode && shift_empty_q && tx_full_q && !busy_q;

  assign sample_now = master_mode ? m_sample : s_sample;
  assign sample_bit = master_mode ? miso_sy_q[1] : mosi_sy_q[1];
  assign byte_done = sample_now && (cnt_q == 4'h7);

  // shift register, bit counter and master sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift_q <= 8'h00;
      out_q <= 1'b0;
      cnt_q <= 4'h0;
      bcnt_q <= 9'h000;
      mst_q <= SPICS_IDLE;
    end
    else if (m_start || s_load)
    begin
      shift_q <= txbuf_q;
      out_q <= txbuf_q[7];
      cnt_q <= 4'h0;
      bcnt_q <= 9'h000;
      mst_q <= m_start ? SPICS_RUN : SPICS_IDLE;
    end
    else if (!master_mode && !selected_flag_filtered)
    begin
      cnt_q <= 4'h0;
      mst_q <= SPICS_IDLE;
    end
    else
    begin
      if (mst_q == SPICS_RUN)
        bcnt_q <= m_end ? 9'h000 : bcnt_q + 9'h001;
      if (sample_now)
      begin
        shift_q <= {shift_q[6:0], sample_bit};
        cnt_q <= byte_done ? 4'h0 : cnt_q + 4'h1;
      end
      if (m_end)
      begin
        out_q <= shift_q[7];
        if (cnt_q == 4'h0)
          mst_q <= SPICS_IDLE;
      end
      if (s_shift)
        out_q <= shift_q[7];
    end
  end

  // busy flag covers the master run and an open slave byte
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_q <= 1'b0;
    else if (master_mode)
      busy_q <= m_start || (mst_q == SPICS_RUN && !(m_end && cnt_q == 4'h0));
    else if (!selected_flag_filtered || byte_done)
      busy_q <= 1'b0;
    else if (s_edge)
      busy_q <= 1'b1;
  end

  // a loaded byte stays pending until it has been shifted out
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ld_q <= 1'b0;
    else if (s_load)
      ld_q <= 1'b1;
    else if (byte_done || master_mode)
      ld_q <= 1'b0;
  end

  // shift-empty flag for slave mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      shift_empty_q <= 1'b1;
    else if (s_load || s_edge)
      shift_empty_q <= 1'b0;
    else if (!master_mode && !busy_q && !ld_q && !tx_full_q && !rx_full_q)
      shift_empty_q <= 1'b1;
  end

  // transmit and receive buffers, set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      txbuf_q <= 8'h00;
      tx_full_q <= 1'b0;
      rxbuf_q <= 8'h00;
      rx_full_q <= 1'b0;
    end
    else
    begin
      if (tx_write)
      begin
        txbuf_q <= hwdata[7:0];
        tx_full_q <= 1'b1;
      end
      else if (m_start || s_load)
        tx_full_q <= 1'b0;
      if (byte_done)
      begin
        rxbuf_q <= {shift_q[6:0], sample_bit};
        rx_full_q <= 1'b1;
      end
      else if (rx_read)
        rx_full_q <= 1'b0;
    end
  end

  // pin drivers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_out_q <= 1'b0;
      sck_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end
    else
    begin
      if (mst_q == SPICS_RUN)
        sck_out_q <= cpol ^ cpha ^ (bcnt_q >= half);
      else
        sck_out_q <= cpol;
      sck_oe_q <= master_mode;
      mosi_oe_q <= master_mode;
      miso_oe_q <= s_active;
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      istat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      istat_q[SPICS_IRQ_DONE] <= byte_done ||
        (istat_q[SPICS_IRQ_DONE] &&
         !(wr_pend_q && wr_addr_q == SPICS_OFF_ISTAT && hwdata[SPICS_IRQ_DONE]));
      istat_q[SPICS_IRQ_SEL] <= sel_rise ||
        (istat_q[SPICS_IRQ_SEL] &&
         !(wr_pend_q && wr_addr_q == SPICS_OFF_ISTAT && hwdata[SPICS_IRQ_SEL]));
      irq_q <= |(istat_q & imask_q);
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign irq = irq_q;
  assign sck_out = sck_out_q;
  assign sck_oe = sck_oe_q;
  assign mosi_out = out_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_out = out_q;
  assign miso_oe = miso_oe_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_cfg_write;
    wr_pend_q && wr_addr_q == SPICS_OFF_CFG;
  endsequence

  a_master_busy_run: assert property (master_mode && mst_q == SPICS_RUN |-> busy_q)
    else $error("busy low during master run");
  a_cfg_write_mask: assert property (s_cfg_write |=> cfg_q == ($past(hwdata[7:0]) & 8'h70))
    else $error("config write not masked");
  a_idle_clock_level: assert property (mst_q == SPICS_IDLE ##1 mst_q == SPICS_IDLE
    |=> sck_out_q == $past(cpol))
    else $error("idle clock level wrong");
  a_sel_follows_filter: assert property (nss_sy_q[1] == 1'b0 [*8]
    |-> selected_flag_filtered)
    else $error("selected flag not set");
  a_glitch_ignored: assert property ($fell(nss_sy_q[1]) ##1 $rose(nss_sy_q[1])
    |-> !selected_flag_filtered)
    else $error("glitch reached selected flag");
  a_master_shift_empty_flag_one: assert property (master_mode |-> shift_empty_flag && receive_empty_flag)
    else $error("master status not one");
  a_shift_empty_flag_clear_edge: assert property (s_edge |=> !shift_empty_q)
    else $error("shift empty kept on edge");
  a_rx_flag_set: assert property (byte_done && !master_mode |=> !receive_empty_flag)
    else $error("receive empty after byte");
  a_master_sample_pos: assert property (m_sample |=> m_end)
    else $error("master sample not one cycle early");
  a_slave_sample_edge: assert property (s_sample |-> s_active && s_edge)
    else $error("slave sample off edge");
  a_raw_pin_read: assert property (rd_take && rd_off == SPICS_OFF_CFG
    |=> hrdata_q[SPICS_BIT_RAW] == $past(nss_sy_q[1]))
    else $error("raw pin bit wrong");
  a_mode_select: assert property (s_cfg_write ##1 1'b1 |-> master_mode == $past(hwdata[6]))
    else $error("mode bit not taken");
  a_shift_empty_flag_set_idle: assert property (!master_mode && !busy_q && !ld_q && !tx_full_q && !rx_full_q
    && !s_edge && !s_load |=> shift_empty_q)
    else $error("shift empty not set");
endmodule // spics_top

// >>> spics_peer.sv
// far-side spi model: master toward a slave-mode block, slave toward a master-mode block
`timescale 1ns/10ps
module spics_peer (
  input wire logic cpha,
  input wire logic cpol,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_out,
  input wire logic miso_out,
  output logic sck_in,
  output logic mosi_in,
  output logic miso_in,
  output logic slave_select_pin
);
  logic [7:0] sl_tx;
  logic [7:0] sl_rx;
  int idx;
  initial
  begin
    sck_in = 1'b0;
    mosi_in = 1'b0;
    miso_in = 1'b0;
    slave_select_pin = 1'b1;
    idx = 8;
  end
  // slave side: sample on leading edge for phase 0, trailing edge for phase 1
  always @(sck_out)
  begin
    if (sck_oe === 1'b1)
    begin
      if ((sck_out != cpol) == !cpha)
        sl_rx = {sl_rx[6:0], mosi_out};
      else
      begin
        miso_in = (idx < 8) ? sl_tx[7 - idx] : ~miso_in;
        idx++;
      end
    end
  end
  task automatic arm(input logic [7:0] b);
    sl_tx = b;
    idx = cpha ? 0 : 1;
    miso_in = cpha ? ~miso_in : b[7];
  endtask
  // master side: one 160 ns link period per bit, clock idles at polarity
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    sck_in = cpol;
    #7;
    slave_select_pin = 1'b0;
    #400;
    for (int i = 7; i >= 0; i--)
    begin
      if (!cpha)
        mosi_in = tx[i];
      #80;
      sck_in = ~cpol;
      if (!cpha)
        rx = {rx[6:0], miso_out};
      #20;
      if (cpha)
        mosi_in = tx[i];
      #60;
      sck_in = cpol;
      if (cpha)
        rx = {rx[6:0], miso_out};
    end
    #80;
    mosi_in = ~mosi_in;
    slave_select_pin = 1'b1;
  endtask
  task automatic set_sel(input logic v);
    slave_select_pin = v;
  endtask
  // low for less than one clock period, so it spans a single sampling edge
  task automatic glitch();
    #15;
    slave_select_pin = 1'b0;
    #10;
    slave_select_pin = 1'b1;
  endtask
endmodule // spics_peer

// >>> spi_config_status_register_tb.sv
// self-checking bench of the spi config/status block
`timescale 1ns/10ps
module spi_config_status_register_tb
  import spics_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, cpha, cpol;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
  logic slave_select_pin;
  int err_count;
  int num_checks;
  int cyc;
  spics_top #(.DEGLITCH_CYC(2)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_in),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out),
    .miso_oe(miso_oe), .slave_select_pin(slave_select_pin));
  spics_peer u_peer (.cpha(cpha), .cpol(cpol), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_out(mosi_out), .miso_out(miso_out), .sck_in(sck_in), .mosi_in(mosi_in),
    .miso_in(miso_in), .slave_select_pin(slave_select_pin));
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single ahb-lite transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? wd : 32'h00000000;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    chk(nm, x, exp);
  endtask
  task automatic t_reset();
    rd_chk("cfg reset", SPICS_OFF_CFG, 32'h00000007);
    rd_chk("div reset", SPICS_OFF_DIV, 32'h00000003);
    rd_chk("unmapped", 8'h20, 32'h00000000);
    wr(SPICS_OFF_CFG, 32'hFFFFFFFF);
    rd_chk("cfg ro bits", SPICS_OFF_CFG, 32'h00000077);
    wr(SPICS_OFF_CFG, 32'h00000000);
  endtask
  task automatic t_select();
    u_peer.glitch();
    repeat (6) @(posedge hclk);
    rd_chk("cfg glitch", SPICS_OFF_CFG, 32'h00000007);
    u_peer.set_sel(1'b0);
    repeat (8) @(posedge hclk);
    rd_chk("cfg selected", SPICS_OFF_CFG, 32'h0000000B);
    u_peer.set_sel(1'b1);
    repeat (8) @(posedge hclk);
    rd_chk("cfg released", SPICS_OFF_CFG, 32'h00000007);
    rd_chk("istat select", SPICS_OFF_ISTAT, 32'h00000002);
    wr(SPICS_OFF_ISTAT, 32'h00000003);
    rd_chk("istat clear", SPICS_OFF_ISTAT, 32'h00000000);
  endtask
  task automatic t_slave(input logic ph, input logic pol);
    logic [7:0] b;
    cpha = ph;
    cpol = pol;
    wr(SPICS_OFF_CFG, {24'h000000, 2'b00, ph, pol, 4'h0});
    wr(SPICS_OFF_TXD, 32'h000000C3);
    rd_chk("cfg tx loaded", SPICS_OFF_CFG, {24'h000000, 2'b00, ph, pol, 4'h5});
    u_peer.xfer(8'h96, b);
    chk("peer rx", {24'h000000, b}, 32'h000000C3);
    repeat (8) @(posedge hclk);
    chk("irq masked", {31'h0, irq}, 32'h00000000);
    rd_chk("cfg rx full", SPICS_OFF_CFG, {24'h000000, 2'b00, ph, pol, 4'h4});
    rd_chk("slave rx", SPICS_OFF_RXD, 32'h00000096);
    rd_chk("cfg drained", SPICS_OFF_CFG, {24'h000000, 2'b00, ph, pol, 4'h7});
    rd_chk("istat slave", SPICS_OFF_ISTAT, 32'h00000003);
    wr(SPICS_OFF_ISTAT, 32'h00000003);
  endtask
  task automatic t_master(input logic [1:0] m);
    logic [31:0] d;
    cpha = m[0];
    cpol = m[1];
    wr(SPICS_OFF_DIV, 32'h00000007);
    wr(SPICS_OFF_IMASK, 32'h00000001);
    wr(SPICS_OFF_CFG, {24'h000000, 2'b01, m[0], m[1], 4'h0});
    repeat (2) @(posedge hclk);
    chk("sck idle", {31'h0, sck_out}, {31'h0, m[1]});
    u_peer.arm(8'h5A ^ {6'h00, m});
    wr(SPICS_OFF_TXD, {24'h000000, 8'hA5 ^ {6'h00, m}});
    bus(1'b0, SPICS_OFF_CFG, 32'h00000000, d);
    chk("busy", {31'h0, d[7]}, 32'h00000001);
    for (int n = 0; n < 300 && irq !== 1'b1; n++) @(posedge hclk);
    chk("irq done", {31'h0, irq}, 32'h00000001);
    rd_chk("cfg idle", SPICS_OFF_CFG, {24'h000000, 2'b01, m[0], m[1], 4'h7});
    rd_chk("master rx", SPICS_OFF_RXD, {24'h000000, 8'h5A ^ {6'h00, m}});
    chk("peer got", {24'h000000, u_peer.sl_rx}, {24'h000000, 8'hA5 ^ {6'h00, m}});
    chk("sck end", {31'h0, sck_out}, {31'h0, m[1]});
    wr(SPICS_OFF_ISTAT, 32'h00000001);
    repeat (3) @(posedge hclk);
    chk("irq clear", {31'h0, irq}, 32'h00000000);
  endtask
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    cpha = 1'b0;
    cpol = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_select();
    t_slave(1'b0, 1'b0);
    t_slave(1'b1, 1'b1);
    for (int m = 0; m < 4; m++)
      t_master(m[1:0]);
    conclude();
  end
endmodule // spi_config_status_register_tb
